// ===== sdio_pkg.sv
// package: register map, field layout and pin carrier types for the static digital io port
package sdio_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_LINES = 32;           // data lines
    localparam int unsigned AUX_BITS   = 4;            // auxiliary port width
    localparam int unsigned ADDR_W     = 8;            // register address width
    localparam int unsigned REG_W      = 32;           // register data width

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DIR       = 8'h00;      // 1 = line is an output
    localparam logic [7:0] OFS_DRV       = 8'h04;      // 1 = open-drain driver
    localparam logic [7:0] OFS_DATA_OUT  = 8'h08;      // output value per line
    localparam logic [7:0] OFS_DATA_IN   = 8'h0C;      // pin levels, read only
    localparam logic [7:0] OFS_GRP_MODE  = 8'h10;      // timed-mode flags per group
    localparam logic [7:0] OFS_AUX_OUT   = 8'h14;      // auxiliary outputs
    localparam logic [7:0] OFS_AUX_IN    = 8'h18;      // auxiliary inputs, read only
    localparam logic [7:0] OFS_STATUS    = 8'h1C;      // availability and pull state

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned GRP1_BIT      = 0;         // group 1 timed flag
    localparam int unsigned GRP2_BIT      = 1;         // group 2 timed flag
    localparam int unsigned ST_AUX_BIT    = 0;         // status: aux port usable
    localparam int unsigned ST_G1_BIT     = 1;         // status: group 1 lines free
    localparam int unsigned ST_G2_BIT     = 2;         // status: group 2 lines free
    localparam int unsigned ST_PULL_DATA  = 3;         // status: data pull select
    localparam int unsigned ST_PULL_CTRL  = 4;         // status: control pull select

    // aux bit positions
    localparam int unsigned AUX_G1_TRIG = 0;           // stop trigger 1 / pclk 1
    localparam int unsigned AUX_G2_TRIG = 1;           // stop trigger 2 / pclk 2
    localparam int unsigned AUX_G1_HS   = 2;           // req 1 / ack 1
    localparam int unsigned AUX_G2_HS   = 3;           // req 2 / ack 2

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_WORD  = 32'h0000_0000; // word reset
    localparam logic [3:0]  RST_AUX   = 4'h0;          // aux reset
    localparam logic [1:0]  RST_GRP   = 2'h0;          // groups idle
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000; // unmapped read value

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;                       // byte address
        logic [REG_W-1:0]  wdata;                      // write data
        logic              wr;                         // write strobe
        logic              rd;                         // read strobe
    } sdio_bus_t;

    typedef struct packed {
        logic [DATA_LINES-1:0] data_out;               // pin output level
        logic [DATA_LINES-1:0] data_oe;                // pin output enable
        logic [DATA_LINES-1:0] pull_level;             // weak pull level
    } sdio_pins_t;

endpackage

// ===== sdio_sync.sv
// module: two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module sdio_sync
    import sdio_pkg::*;
#(
    parameter int unsigned W = 1                       // number of bits
) (
    input  wire logic         i_clk_sys,               // system clock
    input  wire logic         i_rst,                   // sync reset, high
    input  wire logic [W-1:0] i_async,                 // raw pin levels
    output logic      [W-1:0] o_sync                   // synchronised levels
);

    logic [W-1:0] meta;                                // first stage, read by second only

    // ------------------------------------------------------------
    // two stage capture
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule

// ===== sdio_port.sv
// module: static digital io port top with register slave, pin drivers and auxiliary port
// What this block does
// - each of 32 lines: input, push-pull, open-drain
// - static reads and writes act at once
// - push-pull drives both levels, ignores pull
// - pull select sets undriven line level
// - open-drain drives low, releases for one
// - open-drain read returns actual pin level
// - two timing groups, four control lines each
// - timed group withholds its control lines
// - idle groups form 4-bit auxiliary port
// - aux write hits outputs, read returns inputs
// - aux bit to control line mapping fixed
`timescale 1ns/1ps
module sdio_port
    import sdio_pkg::*;
(
    input  wire logic                  i_clk_sys,      // system clock, 125 MHz
    input  wire logic                  i_rst,          // sync reset, active high
    // register port
    input  wire logic [ADDR_W-1:0]     i_addr,         // byte address
    input  wire logic [REG_W-1:0]      i_wdata,        // write data
    input  wire logic                  i_wr,           // write strobe
    input  wire logic                  i_rd,           // read strobe
    output logic      [REG_W-1:0]      o_rdata,        // read data, one cycle later
    // data lines
    input  wire logic [DATA_LINES-1:0] i_data_pin,     // pin levels as seen on the wire
    output logic      [DATA_LINES-1:0] o_data_pin,     // pin drive level
    output logic      [DATA_LINES-1:0] o_data_oe,      // pin drive enable, high drives
    output logic      [DATA_LINES-1:0] o_data_pull,    // weak pull level per line
    input  wire logic                  i_data_pull_select,    // pull select for data lines
    input  wire logic                  i_control_pull_select, // pull select for control lines
    // group 1 and 2 control lines in static use
    input  wire logic [1:0]            i_stop_trigger_line,   // stop trigger 1, 2
    input  wire logic [1:0]            i_req,          // req 1, 2
    output logic      [1:0]            o_pclk,         // peripheral clock 1, 2
    output logic      [1:0]            o_ack,          // ack 1, 2
    output logic      [1:0]            o_ctrl_oe,      // pclk/ack drive enable, both bits set only while both groups idle
    output logic      [1:0]            o_grp_timed     // group is in timed mode
);

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    sdio_bus_t             bus;                        // bundled request
    sdio_pins_t            next_pins;                  // computed pin drive
    logic [DATA_LINES-1:0] dir;                        // 1 = output
    logic [DATA_LINES-1:0] drv_od;                     // 1 = open drain
    logic [DATA_LINES-1:0] data_out;                   // output values
    logic [AUX_BITS-1:0]   aux_out;                    // aux output latch
    logic [1:0]            grp_timed;                  // timed mode per group
    logic [DATA_LINES-1:0] data_in_s;                  // synchronised data pins
    logic [AUX_BITS:0]     ctrl_in_s;                  // synchronised control inputs and control pull
    logic [AUX_BITS-1:0]   aux_in;                     // aux inputs, bit mapped
    logic [1:0]            grp_free;                   // group lines free for static use
    logic                  data_pull_s;                // synced data pull select
    logic                  ctrl_pull_s;                // synced control pull select
    logic [REG_W-1:0]      next_rdata;                 // read mux
    logic [1:0]            next_pclk;                  // pclk drive
    logic [1:0]            next_ack;                   // ack drive

    assign bus.addr  = i_addr;
    assign bus.wdata = i_wdata;
    assign bus.wr    = i_wr;
    assign bus.rd    = i_rd;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // data pins, read back as real wire level
    sdio_sync #(.W(DATA_LINES + 1)) u_sync_data (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   ({i_data_pull_select, i_data_pin}),
        .o_sync    ({data_pull_s, data_in_s})
    );

    // control inputs and control pull select
    sdio_sync #(.W(AUX_BITS + 1)) u_sync_ctrl (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   ({i_control_pull_select, i_req, i_stop_trigger_line}),
        .o_sync    (ctrl_in_s)
    );

    assign ctrl_pull_s = ctrl_in_s[AUX_BITS];

    // aux inputs: bit 0..3 = stop trig 1, stop trig 2, req 1, req 2
    assign aux_in[AUX_G1_TRIG] = ctrl_in_s[0];
    assign aux_in[AUX_G2_TRIG] = ctrl_in_s[1];
    assign aux_in[AUX_G1_HS]   = ctrl_in_s[2];
    assign aux_in[AUX_G2_HS]   = ctrl_in_s[3];

    // a group in timed mode keeps its control lines
    assign grp_free = ~grp_timed;

    // ------------------------------------------------------------
    // direction register
    // ------------------------------------------------------------
    // reset makes every line an input
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            dir <= RST_WORD;
        end else if (bus.wr && bus.addr == OFS_DIR) begin
            dir <= bus.wdata;
        end
    end

    // ------------------------------------------------------------
    // driver type register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            drv_od <= RST_WORD;
        end else if (bus.wr && bus.addr == OFS_DRV) begin
            drv_od <= bus.wdata;
        end
    end

    // ------------------------------------------------------------
    // output data register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            data_out <= RST_WORD;
        end else if (bus.wr && bus.addr == OFS_DATA_OUT) begin
            data_out <= bus.wdata;
        end
    end

    // ------------------------------------------------------------
    // group mode register
    // ------------------------------------------------------------
    // two timing groups, each owning four control lines
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            grp_timed <= RST_GRP;
        end else if (bus.wr && bus.addr == OFS_GRP_MODE) begin
            grp_timed <= bus.wdata[GRP2_BIT:GRP1_BIT];
        end
    end

    // ------------------------------------------------------------
    // aux output register
    // ------------------------------------------------------------
    // write only lands when both groups are idle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            aux_out <= RST_AUX;
        end else if (bus.wr && bus.addr == OFS_AUX_OUT && (&grp_free)) begin
            aux_out <= bus.wdata[AUX_BITS-1:0];
        end
    end

    // ------------------------------------------------------------
    // pin drive computation
    // ------------------------------------------------------------
    always_comb begin
        next_pins.pull_level = {DATA_LINES{data_pull_s}};
        for (int i = 0; i < DATA_LINES; i++) begin
            if (!dir[i]) begin
                // input: released
                next_pins.data_out[i] = 1'b0;
                next_pins.data_oe[i]  = 1'b0;
            end else if (drv_od[i]) begin
                // open drain: drive low only
                next_pins.data_out[i] = 1'b0;
                next_pins.data_oe[i]  = ~data_out[i];
            end else begin
                // push-pull: both levels driven
                next_pins.data_out[i] = data_out[i];
                next_pins.data_oe[i]  = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // control output computation
    // ------------------------------------------------------------
    // outputs 0..3 = pclk 1, pclk 2, ack 1, ack 2
    always_comb begin
        next_pclk[0] = aux_out[AUX_G1_TRIG];
        next_pclk[1] = aux_out[AUX_G2_TRIG];
        next_ack[0]  = aux_out[AUX_G1_HS];
        next_ack[1]  = aux_out[AUX_G2_HS];
    end

    // ------------------------------------------------------------
    // pin output flops
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_data_pin  <= RST_WORD;
            o_data_oe   <= RST_WORD;
            o_data_pull <= RST_WORD;
        end else begin
            o_data_pin  <= next_pins.data_out;
            o_data_oe   <= next_pins.data_oe;
            o_data_pull <= next_pins.pull_level;
        end
    end

    // ------------------------------------------------------------
    // control output flops
    // ------------------------------------------------------------
    // push-pull static outputs only while both groups idle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_pclk      <= RST_GRP;
            o_ack       <= RST_GRP;
            o_ctrl_oe   <= RST_GRP;
            o_grp_timed <= RST_GRP;
        end else begin
            o_pclk      <= next_pclk;
            o_ack       <= next_ack;
            o_ctrl_oe   <= (&grp_free) ? 2'h3 : 2'h0;
            o_grp_timed <= grp_timed;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = ZERO_WORD;
        unique case (bus.addr)
            OFS_DIR:      next_rdata = dir;
            OFS_DRV:      next_rdata = drv_od;
            OFS_DATA_OUT: next_rdata = data_out;
            OFS_DATA_IN:  next_rdata = data_in_s;
            OFS_GRP_MODE: next_rdata = {30'h0000_0000, grp_timed};
            OFS_AUX_OUT:  next_rdata = {28'h000_0000, aux_out};
            OFS_AUX_IN: begin
                // inputs only; zero while a group is timed
                if (&grp_free) begin
                    next_rdata = {28'h000_0000, aux_in};
                end else begin
                    next_rdata = ZERO_WORD;
                end
            end
            OFS_STATUS: begin
                next_rdata[ST_AUX_BIT]   = &grp_free;
                next_rdata[ST_G1_BIT]    = grp_free[0];
                next_rdata[ST_G2_BIT]    = grp_free[1];
                next_rdata[ST_PULL_DATA] = data_pull_s;
                next_rdata[ST_PULL_CTRL] = ctrl_pull_s;
            end
            default:      next_rdata = ZERO_WORD;
        endcase
    end

    // ------------------------------------------------------------
    // read data flop
    // ------------------------------------------------------------
    // data stands only in the cycle after the strobe
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rdata <= ZERO_WORD;
        end else if (bus.rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= ZERO_WORD;
        end
    end

endmodule

// ===== sdio_port_asserts.sv
// checker: port-level assertions for the static digital io port
`timescale 1ns/1ps
module sdio_port_chk
    import sdio_pkg::*;
(
    input  wire logic                  i_clk_sys,             // clock
    input  wire logic                  i_rst,                 // sync reset
    input  wire logic [ADDR_W-1:0]     i_addr,                // address
    input  wire logic [REG_W-1:0]      i_wdata,               // write data
    input  wire logic                  i_wr,                  // write strobe
    input  wire logic                  i_rd,                  // read strobe
    input  wire logic [REG_W-1:0]      o_rdata,               // read data
    input  wire logic [DATA_LINES-1:0] i_data_pin,            // wire level
    input  wire logic [DATA_LINES-1:0] o_data_pin,            // drive level
    input  wire logic [DATA_LINES-1:0] o_data_oe,             // drive enable
    input  wire logic [DATA_LINES-1:0] o_data_pull,           // pull level
    input  wire logic                  i_data_pull_select,    // data pull
    input  wire logic                  i_control_pull_select, // control pull
    input  wire logic [1:0]            i_stop_trigger_line,   // stop triggers
    input  wire logic [1:0]            i_req,                 // req lines
    input  wire logic [1:0]            o_pclk,                // pclk lines
    input  wire logic [1:0]            o_ack,                 // ack lines
    input  wire logic [1:0]            o_ctrl_oe,             // control enable
    input  wire logic [1:0]            o_grp_timed            // timed flags
);
    // ------------------------------------------------------------
    // one clock domain, reset disables every check
    // ------------------------------------------------------------
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // read data only in the cycle after a read
    rdata_idle_a: assert property (
        !$past(i_rd) |-> o_rdata == 32'h0) else $error("read data not zero outside read");
    // no line drives straight out of reset
    reset_idle_a: assert property (
        $past(i_rst) |-> o_data_oe == 32'h0) else $error("line driven after reset");
    // undriven lines follow the pull select
    pull_high_a: assert property (
        i_data_pull_select [*5] |-> o_data_pull == 32'hFFFF_FFFF) else $error("pull not high");
    pull_low_a: assert property (
        !i_data_pull_select [*5] |-> o_data_pull == 32'h0) else $error("pull not low");
    // control outputs driven only while both groups idle
    ctrl_oe_a: assert property (
        !$past(i_rst) |-> o_ctrl_oe == ((o_grp_timed == 2'h0) ? 2'h3 : 2'h0))
        else $error("control enable wrong");
    // aux write refused while a group is timed
    aux_refuse_a: assert property (
        (i_wr && i_addr == OFS_AUX_OUT) ##1 (o_grp_timed != 2'h0) |=> $stable({o_ack, o_pclk}))
        else $error("aux outputs changed while timed");
    // aux write lands on pclk and ack bits
    aux_map_a: assert property (
        (i_wr && i_addr == OFS_AUX_OUT) ##1 (o_grp_timed == 2'h0)
        |=> {28'h0, o_ack, o_pclk} == ($past(i_wdata, 2) & 32'h0000_000F))
        else $error("aux output mapping wrong");
    // data read returns the wire level
    din_read_a: assert property (
        $stable(i_data_pin) [*5] ##0 (i_rd && i_addr == OFS_DATA_IN) |=> o_rdata == $past(i_data_pin))
        else $error("data in read wrong");
    // aux read returns trigger and req inputs
    aux_in_a: assert property (
        $stable({i_req, i_stop_trigger_line}) [*5] ##0 (i_rd && i_addr == OFS_AUX_IN) ##1 (o_grp_timed == 2'h0)
        |-> o_rdata == {28'h0, $past(i_req), $past(i_stop_trigger_line)}) else $error("aux in read wrong");
    aux_timed_a: assert property (
        (i_rd && i_addr == OFS_AUX_IN) ##1 (o_grp_timed != 2'h0) |-> o_rdata == 32'h0)
        else $error("aux in read while timed");
endmodule
bind sdio_port sdio_port_chk i_sdio_port_chk (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_data_pin, .o_data_pin, .o_data_oe, .o_data_pull, .i_data_pull_select, .i_control_pull_select,
    .i_stop_trigger_line, .i_req, .o_pclk, .o_ack, .o_ctrl_oe, .o_grp_timed);

// ===== sdio_periph.sv
// model: peripheral on the data lines, resolves the wire level
`timescale 1ns/1ps
module sdio_periph
    import sdio_pkg::*;
(
    input  wire logic [DATA_LINES-1:0] i_dev_pin,  // device drive level
    input  wire logic [DATA_LINES-1:0] i_dev_oe,   // device drive enable
    input  wire logic [DATA_LINES-1:0] i_pull,     // device weak pull
    input  wire logic [DATA_LINES-1:0] i_per_oe,   // peripheral drive enable
    input  wire logic [DATA_LINES-1:0] i_per_val,  // peripheral drive level
    output logic      [DATA_LINES-1:0] o_wire      // resolved wire level
);
    logic [DATA_LINES-1:0] lo;                     // someone pulls low
    logic [DATA_LINES-1:0] hi;                     // someone drives high
    // wired line: low wins, then high, then the weak pull
    always_comb begin
        lo = (i_dev_oe & ~i_dev_pin) | (i_per_oe & ~i_per_val);
        hi = (i_dev_oe & i_dev_pin) | (i_per_oe & i_per_val);
        o_wire = ~lo & (hi | i_pull);
    end
endmodule

// ===== tb_sdio_port.sv
// testbench: register-level tests of the static digital io port
`timescale 1ns/1ps
module tb_sdio_port;
    import sdio_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    localparam logic [31:0] DIR_V   = 32'h0000_FFFF; // low half outputs
    localparam logic [31:0] DRV_V   = 32'h0000_FF00; // byte 1 open drain
    localparam logic [31:0] DOUT_V  = 32'h0000_A5A5; // output pattern
    localparam logic [31:0] PER_OE  = 32'hFF00_0100; // peripheral drives these
    localparam logic [31:0] PER_VAL = 32'h0F00_0000; // peripheral levels
    logic        i_clk_sys = 1'b0;                  // clock
    logic        i_rst, i_wr, i_rd;                 // reset and strobes
    logic        i_data_pull_select;                // data pull
    logic        i_control_pull_select;             // control pull
    logic [7:0]  i_addr;                            // address
    logic [31:0] i_wdata, o_rdata, wire_lvl;        // bus data and wire
    logic [31:0] o_data_pin, o_data_oe, o_data_pull; // pin drive
    logic [1:0]  i_stop_trigger_line, i_req;        // aux inputs
    logic [1:0]  o_pclk, o_ack, o_ctrl_oe, o_grp_timed; // aux outputs
    int          miscompares, checks_done;          // counters
    always #4 i_clk_sys = ~i_clk_sys;
    sdio_port i_sdio_port (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_data_pin(wire_lvl), .o_data_pin, .o_data_oe, .o_data_pull, .i_data_pull_select,
        .i_control_pull_select, .i_stop_trigger_line, .i_req, .o_pclk, .o_ack, .o_ctrl_oe, .o_grp_timed);
    sdio_periph i_sdio_periph (.i_dev_pin(o_data_pin), .i_dev_oe(o_data_oe), .i_pull(o_data_pull),
        .i_per_oe(PER_OE), .i_per_val(PER_VAL), .o_wire(wire_lvl));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    // read strobe, then sample data in the following cycle
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 chk(nm, o_rdata, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    // wire level expected from line modes, drive values and pull
    function automatic logic [31:0] exp_wire(input logic pull, input logic [31:0] dv);
        logic [31:0] pp;
        logic [31:0] odl;
        pp = DIR_V & ~DRV_V;
        odl = DIR_V & DRV_V & ~dv;
        return (pp & dv) | (~pp & ~odl & ((PER_OE & PER_VAL) | (~PER_OE & {32{pull}})));
    endfunction
    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        miscompares++;
        test_done();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] dv;
        logic [3:0]  av;
        {i_rst, i_wr, i_rd, i_data_pull_select, i_control_pull_select} = 5'h10;
        {i_addr, i_wdata, i_stop_trigger_line, i_req} = 44'h0;
        repeat (8) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        idle(1);
        chk("oe_reset", o_data_oe, 32'h0);
        // mixed modes under both pull levels, both output polarities
        for (int p = 0; p < 2; p++) begin
            dv = p[0] ? ~DOUT_V : DOUT_V;
            @(posedge i_clk_sys);
            i_data_pull_select <= p[0];
            wr(OFS_DIR, DIR_V);
            wr(OFS_DRV, DRV_V);
            wr(OFS_DATA_OUT, dv);
            idle(6);
            chk("oe", o_data_oe, DIR_V & (~DRV_V | ~dv));
            chk("pin", o_data_pin & DIR_V & ~DRV_V, dv & DIR_V & ~DRV_V);
            chk("pin_od", o_data_pin & ~(DIR_V & ~DRV_V), 32'h0);
            chk("pull", o_data_pull, {32{p[0]}});
            rdc(OFS_DATA_IN, exp_wire(p[0], dv), "data_in");
            rdc(OFS_DIR, DIR_V, "dir");
            rdc(OFS_DRV, DRV_V, "drv");
            rdc(OFS_DATA_OUT, dv, "dout");
        end
        // aux port across every group mode
        @(posedge i_clk_sys);
        i_stop_trigger_line <= 2'h1;
        i_req <= 2'h2;
        i_control_pull_select <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            av = (m == 0) ? 4'hA : 4'h5;
            wr(OFS_GRP_MODE, {30'h0, m[1:0]});
            wr(OFS_AUX_OUT, {28'h0, av});
            idle(2);
            chk("aux_out", {28'h0, o_ack, o_pclk}, 32'h0000_000A);
            chk("ctrl_oe", {30'h0, o_ctrl_oe}, (m == 0) ? 32'h3 : 32'h0);
            chk("grp", {30'h0, o_grp_timed}, m);
            rdc(OFS_AUX_IN, (m == 0) ? 32'h9 : 32'h0, "aux_in");
            rdc(OFS_STATUS, {27'h0, 2'h3, ~m[1], ~m[0], m == 0}, "status");
            rdc(OFS_GRP_MODE, m, "grp_reg");
            rdc(OFS_AUX_OUT, 32'hA, "aux_reg");
        end
        wr(OFS_GRP_MODE, 32'h0);
        wr(OFS_AUX_OUT, 32'h5);
        idle(2);
        chk("aux_out2", {28'h0, o_ack, o_pclk}, 32'h5);
        // unmapped place reads zero and leaves the map alone
        wr(8'h40, 32'hFFFF_FFFF);
        rdc(8'h40, 32'h0, "unmapped");
        rdc(OFS_DIR, DIR_V, "dir_kept");
        // reset in mid-run returns every line to input
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        idle(1);
        chk("oe_rerst", o_data_oe, 32'h0);
        rdc(OFS_DIR, 32'h0, "dir_rerst");
        test_done();
    end
endmodule
